// [logic/lhp_pkg.sv]
// Package for the LCD driver host serial port: byte codes, field positions, timing counts.
// Assumes a 10 MHz system clock and a slow link clock sampled by it.
package lhp_pkg;
  localparam int          LHP_CLK_HZ        = 10_000_000;
  localparam int          LHP_FIFO_DEPTH    = 32;
  localparam int          LHP_FIFO_WIDTH    = 9;
  localparam logic [4:0]  LHP_I2C_ADDR_HI   = 5'h0e;
  localparam int          LHP_CHAIN_BIT     = 7;
  localparam int          LHP_SEL_HI_BIT    = 6;
  localparam int          LHP_SEL_LO_BIT    = 5;
  localparam logic [1:0]  LHP_SEL_CMD0      = 2'h0;
  localparam logic [1:0]  LHP_SEL_RAM       = 2'h1;
  localparam logic [1:0]  LHP_SEL_CMD2      = 2'h2;
  localparam logic [1:0]  LHP_SEL_NONE      = 2'h3;
  localparam logic [1:0]  LHP_SPI_SUBADDR   = 2'h1;
  localparam int          LHP_SPI_DIR_BIT   = 7;
  localparam logic [2:0]  LHP_BIT_LAST      = 3'h7;
  localparam logic [8:0]  LHP_RESET_WORD    = 9'h000;

  typedef enum logic [2:0] {
    LHP_IDLE   = 3'b000,
    LHP_ADDR   = 3'b001,
    LHP_CTRL   = 3'b011,
    LHP_DATA   = 3'b010,
    LHP_READ   = 3'b110,
    LHP_IGNORE = 3'b111
  } lhp_state_t;
endpackage

// [logic/lhp_sync.sv]
// Two-flip-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to clk_sys_in.
`timescale 1ns/100ps
`default_nettype none
module lhp_sync
  import lhp_pkg::*;
#(
  parameter int W = 4
)
(
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      meta_q   <= '1;
      sync_out <= '1;
    end
    else if (ce_in)
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [logic/lhp_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides and honest full and empty.
// Assumes one clock domain; drain side may stall.
`timescale 1ns/100ps
`default_nettype none
module lhp_fifo
  import lhp_pkg::*;
#(
  parameter int WIDTH = LHP_FIFO_WIDTH,
  parameter int DEPTH = LHP_FIFO_DEPTH
)
(
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic             flush_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_q != '0);
  assign rd_data_out  = mem_q[rd_ptr_q];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  always_ff @(posedge clk_sys_in)
  begin
    if (ce_in && push)
    begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else if (ce_in)
    begin
      if (flush_in)
      begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        count_q  <= '0;
      end
      else
      begin
        if (push)
        begin
          wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
        end
        if (pop)
        begin
          rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
        end
        count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule
`default_nettype wire

// [logic/lhp_host_port.sv]
// Host serial port of an LCD segment driver: two-wire slave or four-wire SPI slave.
// Assumes pins are asynchronous and the link clock is far slower than clk_sys_in.
//
// Contract
// - Strap low selects SPI slave; strap high selects two-wire slave.
// - Control byte bit 7 zero marks last control byte; one chains another.
// - Select field 00 or 10 routes to commands, 01 to display RAM.
// - RAM bytes go to display RAM at the data pointer location.
// - One bit per clock pulse; data stable while clock is high.
// - Data falling with clock high is start; rising with clock high is stop.
// - Any number of bytes; each 8-bit byte is followed by acknowledge.
// - Addressed receiver pulls data low through the acknowledge clock high phase.
// - Master nacks last read byte; device then releases the data line.
// - Device is slave only; outputs only acknowledges and temperature byte.
// - Two-wire address is 01110, then strap high, strap low bits.
// - Address bit 0 is direction: zero write, one read.
// - Matching devices acknowledge; others ignore the transfer until stop.
// - Read direction makes the device send one temperature byte.
// - SPI chip enable is active low; high holds the interface in reset.
// - SPI samples serial data on the rising serial clock edge.
// - SPI bytes are MSB first; first byte is the subaddress.
// - SPI subaddress byte carries direction flag and subaddress.
// - Subaddress bit 7 is direction; bits 6 to 5 must be 01.
// - RAM bytes are delivered on arrival, before the acknowledge cycle.
`timescale 1ns/100ps
`default_nettype none
module lhp_host_port
  import lhp_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       interface_select_pin_in,
  input  wire logic       address_strap_low_in,
  input  wire logic       address_strap_high_in,
  input  wire logic       scl_in,
  input  wire logic       serial_data_input_pin_in,
  input  wire logic       chip_enable_n_in,
  output logic            ack_output_pin_out,
  output logic            ack_output_pin_oe_out,
  output logic            serial_data_output_pin_out,
  output logic            serial_data_output_pin_oe_out,
  input  wire logic [7:0] temperature_in,
  output logic [7:0]      cmd_data_out,
  output logic            cmd_valid_out,
  input  wire logic       cmd_ready_in,
  output logic [7:0]      ram_data_out,
  output logic            ram_valid_out,
  input  wire logic       ram_ready_in,
  output logic            frame_active_out,
  output logic            early_end_out,
  output logic            overflow_out
);
  logic [4:0]  pins_raw;
  logic [4:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        cen_s;
  logic        sa0_s;
  logic        sa1_s;
  logic        scl_d1_q;
  logic        sda_d1_q;
  logic        mode_i2c_q;
  lhp_state_t  state_q;
  logic [7:0]  shift_q;
  logic [2:0]  bit_q;
  logic        in_ack_q;
  logic        chain_q;
  logic [1:0]  sel_q;
  logic        ack_drive_q;
  logic [7:0]  tx_q;
  logic        tx_drive_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        spi_reset;
  logic        byte_done;
  logic [7:0]  rx_byte;
  logic        push_valid;
  logic [8:0]  push_word;
  logic        push_ready;
  logic [8:0]  pop_word;
  logic        pop_valid;
  logic        pop_ready;
  logic        frame_q;
  logic        data_seen_q;

  function automatic logic sel_is_cmd(input logic [1:0] sel);
    return (sel == LHP_SEL_CMD0) || (sel == LHP_SEL_CMD2);
  endfunction

  assign pins_raw = {address_strap_high_in, address_strap_low_in, chip_enable_n_in,
                     serial_data_input_pin_in, scl_in};

  lhp_sync #(
    .W (5)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .async_in   (pins_raw),
    .sync_out   (pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign cen_s = pins_s[2];
  assign sa0_s = pins_s[3];
  assign sa1_s = pins_s[4];

  // Interface mode is sampled from the strap while reset is held, then kept.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      mode_i2c_q <= interface_select_pin_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end
    else if (ce_in)
    begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end

  assign scl_rise   = scl_s && !scl_d1_q;
  assign scl_fall   = !scl_s && scl_d1_q;
  assign start_cond = mode_i2c_q && scl_s && scl_d1_q && sda_d1_q && !sda_s;
  assign stop_cond  = mode_i2c_q && scl_s && scl_d1_q && !sda_d1_q && sda_s;
  assign spi_reset  = !mode_i2c_q && cen_s;
  assign rx_byte    = {shift_q[6:0], sda_s};
  assign byte_done  = scl_rise && !in_ack_q && (bit_q == LHP_BIT_LAST);

  // Bits are shifted in MSB first on each rising clock edge outside the acknowledge clock; data is stable then.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      shift_q  <= '0;
      bit_q    <= '0;
      in_ack_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (start_cond || stop_cond || spi_reset || state_q == LHP_IDLE)
      begin
        bit_q    <= '0;
        in_ack_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (in_ack_q)
        begin
          in_ack_q <= 1'b0;
        end
        else
        begin
          shift_q <= rx_byte;
          bit_q   <= bit_q + 3'h1;
          in_ack_q <= mode_i2c_q && (bit_q == LHP_BIT_LAST);
        end
      end
    end
  end

  // Protocol walk: address, control bytes, data bytes, read or ignore.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= LHP_IDLE;
      chain_q <= 1'b0;
      sel_q   <= LHP_SEL_NONE;
    end
    else if (ce_in)
    begin
      if (stop_cond || spi_reset)
      begin
        state_q <= LHP_IDLE;
      end
      else if (start_cond)
      begin
        state_q <= LHP_ADDR;
      end
      else if (state_q == LHP_IDLE && !mode_i2c_q && !cen_s)
      begin
        state_q <= LHP_ADDR;
      end
      else if (byte_done)
      begin
        unique case (state_q)
          LHP_ADDR:
          begin
            if (mode_i2c_q)
            begin
              if (rx_byte[7:3] == LHP_I2C_ADDR_HI && rx_byte[2] == sa1_s
                  && rx_byte[1] == sa0_s)
              begin
                state_q <= rx_byte[0] ? LHP_READ : LHP_CTRL;
              end
              else
              begin
                state_q <= LHP_IGNORE;
              end
            end
            else if (rx_byte[LHP_SEL_HI_BIT:LHP_SEL_LO_BIT] == LHP_SPI_SUBADDR)
            begin
              state_q <= rx_byte[LHP_SPI_DIR_BIT] ? LHP_READ : LHP_CTRL;
            end
            else
            begin
              state_q <= LHP_IGNORE;
            end
          end
          LHP_CTRL:
          begin
            chain_q <= rx_byte[LHP_CHAIN_BIT];
            sel_q   <= rx_byte[LHP_SEL_HI_BIT:LHP_SEL_LO_BIT];
            state_q <= LHP_DATA;
          end
          LHP_DATA:
          begin
            state_q <= chain_q ? LHP_CTRL : LHP_DATA;
          end
          LHP_READ:
          begin
            state_q <= LHP_IGNORE;
          end
          LHP_IGNORE:
          begin
            state_q <= LHP_IGNORE;
          end
          LHP_IDLE:
          begin
            state_q <= LHP_IDLE;
          end
        endcase
      end
    end
  end

  // Data bytes leave at the last bit, before any acknowledge.
  assign push_valid = ce_in && byte_done && state_q == LHP_DATA
                      && sel_q != LHP_SEL_NONE;
  assign push_word  = {sel_is_cmd(sel_q), rx_byte};

  lhp_fifo #(
    .WIDTH (LHP_FIFO_WIDTH),
    .DEPTH (LHP_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .flush_in     (1'b0),
    .wr_data_in   (push_word),
    .wr_valid_in  (push_valid),
    .wr_ready_out (push_ready),
    .rd_data_out  (pop_word),
    .rd_valid_out (pop_valid),
    .rd_ready_in  (pop_ready)
  );

  assign cmd_data_out  = pop_word[7:0];
  assign ram_data_out  = pop_word[7:0];
  assign cmd_valid_out = pop_valid && pop_word[8];
  assign ram_valid_out = pop_valid && !pop_word[8];
  assign pop_ready     = pop_word[8] ? cmd_ready_in : ram_ready_in;

  // A byte that finds the buffer full is lost and flagged.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      overflow_out <= 1'b0;
    end
    else if (ce_in)
    begin
      overflow_out <= push_valid && !push_ready;
    end
  end

  // Acknowledge pulls low for the whole ninth clock of an addressed write byte or read address byte.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      ack_drive_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (start_cond || stop_cond || !mode_i2c_q)
      begin
        ack_drive_q <= 1'b0;
      end
      else if (scl_fall && in_ack_q)
      begin
        ack_drive_q <= (state_q == LHP_CTRL || state_q == LHP_DATA
                        || state_q == LHP_READ) && !tx_drive_q;
      end
      else if (scl_fall)
      begin
        ack_drive_q <= 1'b0;
      end
    end
  end

  assign ack_output_pin_out    = 1'b0;
  assign ack_output_pin_oe_out = ack_drive_q;

  // Temperature byte goes out MSB first after a read address, then lines release.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      tx_q       <= '0;
      tx_drive_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (start_cond || stop_cond || spi_reset || (scl_fall && tx_drive_q && state_q != LHP_READ))
      begin
        tx_drive_q <= 1'b0;
      end
      else if (scl_fall && state_q == LHP_READ && !in_ack_q && bit_q == '0 && !tx_drive_q)
      begin
        tx_q       <= temperature_in;
        tx_drive_q <= 1'b1;
      end
      else if (scl_fall && tx_drive_q)
      begin
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  assign serial_data_output_pin_out    = tx_q[7];
  assign serial_data_output_pin_oe_out = tx_drive_q && (mode_i2c_q ? !tx_q[7] : 1'b1);

  // Frame status and early end detection for the data pointer owner.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      frame_q       <= 1'b0;
      data_seen_q   <= 1'b0;
      early_end_out <= 1'b0;
    end
    else if (ce_in)
    begin
      frame_q       <= state_q != LHP_IDLE && state_q != LHP_IGNORE;
      early_end_out <= (stop_cond || spi_reset || start_cond) && frame_q
                       && bit_q != '0 && data_seen_q;
      if (state_q == LHP_IDLE)
      begin
        data_seen_q <= 1'b0;
      end
      else if (push_valid)
      begin
        data_seen_q <= 1'b1;
      end
    end
  end

  assign frame_active_out = frame_q;
endmodule
`default_nettype wire

// [dv/lhp_host_port_assertions.sv]
// Checker for the host serial port: pin and stream timing relations.
// Assumes it is bound to lhp_host_port and that the link clock is slow next to clk_sys_in.
`timescale 1ns/100ps
`default_nettype none
module lhp_host_port_assertions
  import lhp_pkg::*;
(
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic       interface_select_pin_in,
  input wire logic       scl_in,
  input wire logic       chip_enable_n_in,
  input wire logic       ack_output_pin_out,
  input wire logic       ack_output_pin_oe_out,
  input wire logic       serial_data_output_pin_out,
  input wire logic       serial_data_output_pin_oe_out,
  input wire logic [7:0] cmd_data_out,
  input wire logic       cmd_valid_out,
  input wire logic       cmd_ready_in,
  input wire logic [7:0] ram_data_out,
  input wire logic       ram_valid_out,
  input wire logic       ram_ready_in,
  input wire logic       frame_active_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  a_spi_no_ack: assert property (!interface_select_pin_in |-> !ack_output_pin_oe_out)
    else $error("ack pin driven in four-wire mode");
  a_ack_level: assert property (ack_output_pin_out == 1'b0)
    else $error("ack pin drives a high level");
  a_ack_stands: assert property ($rose(ack_output_pin_oe_out) |-> ack_output_pin_oe_out [*7])
    else $error("ack released before the ack clock ended");
  a_od_only_low: assert property (interface_select_pin_in && serial_data_output_pin_oe_out
    |-> !serial_data_output_pin_out)
    else $error("two-wire data output drives high");
  a_ce_resets: assert property ((!interface_select_pin_in && chip_enable_n_in) [*6]
    |-> !frame_active_out && !serial_data_output_pin_oe_out)
    else $error("interface active while chip enable high");
  a_sdo_on_fall: assert property (!interface_select_pin_in && serial_data_output_pin_oe_out
    && $changed(serial_data_output_pin_out) |-> !scl_in)
    else $error("serial output changed while clock high");
  a_cmd_hold: assert property (cmd_valid_out && !cmd_ready_in
    |=> cmd_valid_out && $stable(cmd_data_out))
    else $error("command byte dropped or changed while stalled");
  a_ram_hold: assert property (ram_valid_out && !ram_ready_in
    |=> ram_valid_out && $stable(ram_data_out))
    else $error("display byte dropped or changed while stalled");
  a_ram_first: assert property ($rose(ram_valid_out) && interface_select_pin_in
    && frame_active_out |-> !ack_output_pin_oe_out ##[1:12] ack_output_pin_oe_out)
    else $error("display byte not delivered ahead of its ack");
endmodule

bind lhp_host_port lhp_host_port_assertions i_lhp_host_port_assertions (
  .clk_sys_in, .rst_n_in, .interface_select_pin_in, .scl_in, .chip_enable_n_in,
  .ack_output_pin_out, .ack_output_pin_oe_out, .serial_data_output_pin_out,
  .serial_data_output_pin_oe_out, .cmd_data_out, .cmd_valid_out, .cmd_ready_in,
  .ram_data_out, .ram_valid_out, .ram_ready_in, .frame_active_out
);
`default_nettype wire

// [dv/lhp_bus_master.sv]
// Bus master model for the host serial port, two-wire and four-wire framing.
// Assumes the bench resolves the shared data wire and calls these tasks in order.
`timescale 1ns/100ps
`default_nettype none
module lhp_bus_master
  import lhp_pkg::*;
(
  output logic      scl_out,
  output logic      sda_out,
  output logic      ce_n_out,
  input  wire logic sda_in,
  input  wire logic sdo_in
);
  bit spi;

  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    ce_n_out = 1'b1;
  end

  task automatic mode(input bit s);
    spi = s;
    scl_out = !s;
  endtask

  task automatic start();
    #13;
    if (spi)
      ce_n_out = 1'b0;
    else
      #400 sda_out = 1'b0;
    #400 scl_out = 1'b0;
  endtask

  task automatic bit_io(input logic b, output logic r);
    #200 sda_out = b;
    #200 scl_out = 1'b1;
    #200 r = spi ? sdo_in : sda_in;
    #200 scl_out = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q, output logic ack);
    ack = 1'b0;
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--)
      bit_io(d[i], q[i]);
    if (!spi && n == 8)
      bit_io(1'b1, ack);
  endtask

  task automatic stop();
    if (spi)
    begin
      #200 ce_n_out = 1'b1;
      sda_out = ~sda_out;
    end
    else
    begin
      #200 sda_out = 1'b0;
      #200 scl_out = 1'b1;
      #200 sda_out = 1'b1;
    end
    #400;
  endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the host serial port in both link modes.
// Assumes the bus master model and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import lhp_pkg::*;
();
  typedef struct packed {logic [7:0] ctrl; logic [7:0] data; logic [1:0] route;} lhp_row_t;
  localparam logic [7:0] addr_w = {LHP_I2C_ADDR_HI, 2'b10, 1'b0};
  lhp_row_t   rows [4] = '{'{8'h00, 8'h3c, 2'h0}, '{8'h40, 8'hc3, 2'h0},
                           '{8'h20, 8'h5a, 2'h1}, '{8'h60, 8'h99, 2'h2}};
  logic [7:0] bad [3] = '{8'h00, 8'h40, 8'h60};
  logic       clk_sys_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       interface_select_pin_in = 1'b1;
  logic       cmd_ready_in = 1'b0;
  logic       ram_ready_in = 1'b0;
  logic [7:0] temperature_in = 8'hb6;
  logic       seen_end = 1'b0;
  logic       seen_ovf = 1'b0;
  logic       scl_in, chip_enable_n_in, m_sda, sda_w, sdo_w, a;
  logic       serial_data_input_pin_in, ack_output_pin_out, ack_output_pin_oe_out;
  logic       serial_data_output_pin_out, serial_data_output_pin_oe_out;
  logic       cmd_valid_out, ram_valid_out, frame_active_out, early_end_out, overflow_out;
  logic [7:0] cmd_data_out, ram_data_out, q;
  int         n_mismatch = 0;
  int         total_checks = 0;

  always #50 clk_sys_in = ~clk_sys_in;
  assign sda_w = m_sda & ~ack_output_pin_oe_out
               & ~(serial_data_output_pin_oe_out & ~serial_data_output_pin_out);
  assign sdo_w = serial_data_output_pin_oe_out ? serial_data_output_pin_out : 1'bz;
  assign serial_data_input_pin_in = interface_select_pin_in ? sda_w : m_sda;

  always @(posedge clk_sys_in)
  begin
    if (early_end_out)
      seen_end <= 1'b1;
    if (overflow_out)
      seen_ovf <= 1'b1;
  end

  lhp_host_port i_lhp_host_port (
    .clk_sys_in, .rst_n_in, .ce_in(1'b1), .interface_select_pin_in,
    .address_strap_low_in(1'b0), .address_strap_high_in(1'b1), .scl_in,
    .serial_data_input_pin_in, .chip_enable_n_in, .ack_output_pin_out, .ack_output_pin_oe_out,
    .serial_data_output_pin_out, .serial_data_output_pin_oe_out, .temperature_in,
    .cmd_data_out, .cmd_valid_out, .cmd_ready_in, .ram_data_out, .ram_valid_out,
    .ram_ready_in, .frame_active_out, .early_end_out, .overflow_out
  );
  lhp_bus_master i_lhp_bus_master (
    .scl_out(scl_in), .sda_out(m_sda), .ce_n_out(chip_enable_n_in),
    .sda_in(sda_w), .sdo_in(sdo_w)
  );

  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_f(input logic got, input logic exp);
    chk_b({7'h00, got}, {7'h00, exp});
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic xf(input logic [7:0] d, input int n = 8);
    i_lhp_bus_master.xfer(d, n, q, a);
  endtask

  task automatic do_reset(input logic mode);
    @(negedge clk_sys_in);
    rst_n_in = 1'b0;
    interface_select_pin_in = mode;
    i_lhp_bus_master.mode(!mode);
    repeat (20) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk_f(ack_output_pin_oe_out | serial_data_output_pin_oe_out, 1'b0);
    chk_f(cmd_valid_out | ram_valid_out, 1'b0);
    fin("reset");
  endtask

  task automatic frame(input logic [7:0] hdr, input logic [7:0] ctl, input logic [7:0] dat,
                       input logic ack_exp);
    i_lhp_bus_master.start();
    xf(hdr);
    chk_f(a, ack_exp);
    xf(ctl);
    xf(dat);
    chk_f(a, ack_exp);
    i_lhp_bus_master.stop();
  endtask

  task automatic pop(input logic [1:0] route, input logic [7:0] exp);
    @(negedge clk_sys_in);
    chk_f(cmd_valid_out, route == 2'h0);
    chk_f(ram_valid_out, route == 2'h1);
    if (route != 2'h2)
      chk_b(route == 2'h1 ? ram_data_out : cmd_data_out, exp);
    cmd_ready_in = (route == 2'h0);
    ram_ready_in = (route == 2'h1);
    @(negedge clk_sys_in);
    cmd_ready_in = 1'b0;
    ram_ready_in = 1'b0;
  endtask

  initial
  begin
    #4_000_000;
    n_mismatch++;
    results();
  end

  initial
  begin
    do_reset(1'b1);
    for (int i = 0; i < 4; i++)
    begin
      frame(addr_w, rows[i].ctrl, rows[i].data, 1'b0);
      pop(rows[i].route, rows[i].data);
    end
    fin("routing");
    i_lhp_bus_master.start();
    xf(addr_w);
    xf(8'h80);
    xf(8'h11);
    xf(8'h20);
    xf(8'h22);
    i_lhp_bus_master.stop();
    pop(2'h0, 8'h11);
    pop(2'h1, 8'h22);
    fin("chain");
    frame(addr_w ^ 8'h06, 8'h00, 8'h33, 1'b1);
    pop(2'h2, 8'h00);
    fin("address");
    i_lhp_bus_master.start();
    xf(addr_w | 8'h01);
    chk_f(a, 1'b0);
    xf(8'hff);
    chk_b(q, temperature_in);
    chk_f(a, 1'b1);
    i_lhp_bus_master.stop();
    pop(2'h2, 8'h00);
    fin("read");
    do_reset(1'b0);
    frame(8'h20, 8'h20, 8'ha5, 1'b0);
    pop(2'h1, 8'ha5);
    for (int i = 0; i < 3; i++)
    begin
      frame(bad[i], 8'h00, 8'h77, 1'b0);
      pop(2'h2, 8'h00);
    end
    fin("subaddress");
    i_lhp_bus_master.start();
    xf(8'ha0);
    xf(8'h00);
    chk_b(q, temperature_in);
    i_lhp_bus_master.stop();
    fin("spi read");
    i_lhp_bus_master.start();
    xf(8'h20);
    xf(8'h00);
    xf(8'h44);
    xf(8'h00, 3);
    i_lhp_bus_master.stop();
    chk_f(seen_end, 1'b1);
    pop(2'h0, 8'h44);
    frame(8'h20, 8'h00, 8'h55, 1'b0);
    pop(2'h0, 8'h55);
    fin("abort");
    i_lhp_bus_master.start();
    xf(8'h20);
    xf(8'h20);
    for (int i = 0; i < 33; i++)
      xf(i[7:0]);
    i_lhp_bus_master.stop();
    chk_f(seen_ovf, 1'b1);
    for (int i = 0; i < 32; i++)
      pop(2'h1, i[7:0]);
    pop(2'h2, 8'h00);
    fin("fifo");
    results();
  end
endmodule
`default_nettype wire
